// >>> pkg/srt_pkg.sv
// Constants, carriers and helpers for the sample-rate timing and record count block
package srt_pkg;

    // -----------------------------------------------------------------
    // Clock rates
    // -----------------------------------------------------------------
    localparam int          CLK_MHZ       = 125;
    localparam int          MASTER_MHZ    = 50;
    localparam logic [7:0]  ACC_STEP      = 8'(MASTER_MHZ);
    localparam logic [7:0]  ACC_WRAP      = 8'(CLK_MHZ);
    localparam logic [2:0]  DIV5_LAST     = 3'h4;
    localparam logic [2:0]  DIV5_HIGH     = 3'h2;

    // -----------------------------------------------------------------
    // Decade counters
    // -----------------------------------------------------------------
    localparam logic [3:0]  DEC_FULL      = 4'h9;
    localparam logic [3:0]  DEC_ZERO      = 4'h0;
    localparam int          CHAIN_STAGES  = 4;
    localparam int          RATE_HI_BIT   = 7;
    localparam int          RATE_LO_BIT   = 6;
    localparam int          PRE_AC_BIT    = 0;
    localparam int          PRE_D_BIT     = 1;
    localparam int          CHAIN_LSB_BIT = 2;
    localparam logic [1:0]  SEL_25M       = 2'h0;
    localparam logic [1:0]  SEL_10M       = 2'h1;
    localparam logic [1:0]  SEL_5M        = 2'h2;
    localparam logic [1:0]  SEL_CHAIN     = 2'h3;
    localparam logic [3:0]  DIV10_PRESET  = 4'h3;
    localparam logic [3:0]  DIV10_LAST    = 4'hC;
    localparam int          DIV10_MSB     = 3;

    // -----------------------------------------------------------------
    // Record counter
    // -----------------------------------------------------------------
    localparam logic [7:0]  LOW_FULL      = 8'hFF;
    localparam logic [11:0] PRESET_POST   = 12'h040;
    localparam logic [11:0] PRESET_PRE    = 12'h1C0;
    localparam int          DONE_BIT      = 9;

    // -----------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // -----------------------------------------------------------------
    localparam logic [3:0]  REG_RATE      = 4'h0;
    localparam logic [3:0]  REG_MODE      = 4'h4;
    localparam logic [3:0]  REG_STATUS    = 4'h8;
    localparam logic [7:0]  RATE_RESET    = 8'h00;
    localparam int          ST_DONE_BIT   = 0;
    localparam int          ST_STOP_BIT   = 1;
    localparam int          ST_COUNT_LSB  = 8;

    // Mode register layout, bit 3 downward
    typedef struct packed {
        logic chain_service_jumper;
        logic pretrigger;
        logic envelope_select;
        logic short_period_select;
    } srt_mode_t;
    localparam srt_mode_t   MODE_RESET    = '0;

    // Outputs toward converter, memory and interval meter
    typedef struct packed {
        logic convert;
        logic store;
        logic meter_clock;
    } srt_strobes_t;

    // One decade step, shared by the prescaler and the chain decades
    function automatic logic [3:0] srt_next_decade(input logic [3:0] q);
        srt_next_decade = (q == DEC_FULL) ? DEC_ZERO : 4'(q + 4'h1);
    endfunction : srt_next_decade

endpackage : srt_pkg

// >>> hdl/srt_decade.sv
// Synchronous presettable decade counter with enable and carry
`timescale 1ns/100ps
module srt_decade
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       enable,
    input  wire logic       load,
    input  wire logic [3:0] preset,
    output logic      [3:0] count,
    output logic            carry
);
    import srt_pkg::*;

    // Carry only while enabled, so a stalled stage never ripples on
    assign carry = enable && (count == DEC_FULL);

    // Load wins over counting; reset to full count so the first chain load
    // follows the first prescaler carry instead of a 10,000-step wrap
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= DEC_FULL;
        else if (load)
            count <= preset;
        else if (enable)
            count <= srt_next_decade(count);
    end

endmodule : srt_decade

// >>> hdl/srt_timing.sv
// Sample-rate divide chain, strobe generator and record counter
`timescale 1ns/100ps
module srt_timing
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [3:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    input  wire logic                  acquisition_active,
    input  wire logic                  triggered,
    output srt_pkg::srt_strobes_t      strobes,
    output logic                       done
);
    import srt_pkg::*;

    // -----------------------------------------------------------------
    // Register bus
    // -----------------------------------------------------------------
    logic        ack;
    logic [7:0]  sample_rate_setting;
    srt_mode_t   mode;
    logic [11:0] record_count;
    logic        stop;
    wire         bus_take          = (read || write) && ack;
    wire         rate_write_strobe = write && ack && (address == REG_RATE);
    wire         mode_write        = write && ack && (address == REG_MODE);
    wire [31:0]  status_word       = {12'h000, record_count, 6'h00, stop, done};
    wire [31:0]  read_mux          = (address == REG_RATE)   ? {24'h0, sample_rate_setting} :
                                     (address == REG_MODE)   ? {28'h0, mode} :
                                     (address == REG_STATUS) ? status_word : 32'h0;

    // One wait cycle per access; the answer lands on the second edge
    assign waitrequest = (read || write) && !ack;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ack <= 1'b0;
        else
            ack <= (read || write) && !ack;
    end

    // Readable settings held until the next write strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sample_rate_setting <= RATE_RESET;
            mode                <= MODE_RESET;
        end
        else
        begin
            if (rate_write_strobe)
                sample_rate_setting <= writedata[7:0];
            if (mode_write)
                mode <= srt_mode_t'(writedata[3:0]);
        end
    end

    // Read data loaded in the wait cycle so it stands at the accepting edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            readdata <= 32'h0;
        else if (read && !ack)
            readdata <= read_mux;
    end

    // -----------------------------------------------------------------
    // Master clock enables
    // -----------------------------------------------------------------
    // A phase accumulator makes a 50 MHz tick out of clk; the tick jitters by
    // one clk period, traded for keeping a single clock domain.
    logic [7:0] phase_acc;
    logic [2:0] div5;
    logic       c25;
    logic       c5;
    wire [7:0]  acc_sum        = 8'(phase_acc + ACC_STEP);
    wire        master_tick    = (acc_sum >= ACC_WRAP);
    wire        clk_25m_enable = master_tick && !c25;
    wire        clk_10m_enable = master_tick && (div5 == DIV5_LAST);
    wire        clk_5m_enable  = clk_10m_enable && !c5;
    wire        c10            = (div5 < DIV5_HIGH);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_acc <= 8'h00;
            div5      <= 3'h0;
            c25       <= 1'b0;
            c5        <= 1'b0;
        end
        else
        begin
            phase_acc <= master_tick ? 8'(acc_sum - ACC_WRAP) : acc_sum;
            if (master_tick)
            begin
                c25  <= !c25;
                div5 <= (div5 == DIV5_LAST) ? 3'h0 : 3'(div5 + 3'h1);
            end
            if (clk_10m_enable)
                c5 <= !c5;
        end
    end

    // -----------------------------------------------------------------
    // Sample rate divide chain
    // -----------------------------------------------------------------
    wire        rate_select_hi = sample_rate_setting[RATE_HI_BIT];
    wire        rate_select_lo = sample_rate_setting[RATE_LO_BIT];
    wire        chain_run      = rate_select_hi && rate_select_lo;
    // Preset digit is D C B A with A and C tied and B held low
    wire [3:0]  pre_preset     = {sample_rate_setting[PRE_D_BIT],
                                  sample_rate_setting[PRE_AC_BIT], 1'b0,
                                  sample_rate_setting[PRE_AC_BIT]};
    logic [3:0] prescaler_counter;
    logic       pre_carry;
    logic [CHAIN_STAGES:0] stage_carry;
    logic       chain_sync_ff;

    // Prescaler reloads itself on its own carry, jumper or not
    srt_decade u_prescaler
    (
        .clk     (clk),
        .reset_n (reset_n),
        .enable  (clk_5m_enable && chain_run),
        .load    (clk_5m_enable && pre_carry),
        .preset  (pre_preset),
        .count   (prescaler_counter),
        .carry   (pre_carry)
    );

    // Carry seen by the decades only on a 5 MHz step
    assign stage_carry[0] = pre_carry && clk_5m_enable;

    wire chain_load_gate = stage_carry[CHAIN_STAGES] && stage_carry[0];
    wire chain_load      = chain_load_gate && !mode.chain_service_jumper;

    genvar gi;
    generate
        for (gi = 0; gi < CHAIN_STAGES; gi++)
        begin : g_chain
            // Digit is 9 (pass carry) or 0 (divide by ten)
            wire [3:0] digit = sample_rate_setting[CHAIN_LSB_BIT + gi] ? DEC_FULL : DEC_ZERO;
            srt_decade u_stage
            (
                .clk     (clk),
                .reset_n (reset_n),
                .enable  (stage_carry[gi]),
                .load    (chain_load),
                .preset  (digit),
                .count   (),
                .carry   (stage_carry[gi + 1])
            );
        end
    endgenerate

    // High for one 5 MHz period after each load event
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            chain_sync_ff <= 1'b0;
        else if (clk_5m_enable)
            chain_sync_ff <= chain_load_gate;
    end

    // -----------------------------------------------------------------
    // Timing signal selection
    // -----------------------------------------------------------------
    wire [1:0] rate_sel   = {rate_select_hi, rate_select_lo};
    wire       chain_rise = clk_5m_enable && chain_load_gate;
    wire       timing_signal = (rate_sel == SEL_25M) ? c25 :
                               (rate_sel == SEL_10M) ? c10 :
                               (rate_sel == SEL_5M)  ? c5  : chain_sync_ff;
    wire       ts_rise       = (rate_sel == SEL_25M) ? clk_25m_enable :
                               (rate_sel == SEL_10M) ? clk_10m_enable :
                               (rate_sel == SEL_5M)  ? clk_5m_enable  : chain_rise;

    // -----------------------------------------------------------------
    // Divide-by-ten stage
    // -----------------------------------------------------------------
    logic [3:0] div10_counter;
    logic       div10_sync_ff;
    wire        div10_at_last = (div10_counter == DIV10_LAST);
    wire        div10_rise    = clk_5m_enable && div10_counter[DIV10_MSB] && !div10_sync_ff;

    // Counts 3..12 on timing signal steps; ten states, MSB high for five
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            div10_counter <= DIV10_PRESET;
        else if (ts_rise)
            div10_counter <= div10_at_last ? DIV10_PRESET : 4'(div10_counter + 4'h1);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            div10_sync_ff <= 1'b0;
        else if (clk_5m_enable)
            div10_sync_ff <= div10_counter[DIV10_MSB];
    end

    // -----------------------------------------------------------------
    // Strobe selection and gating
    // -----------------------------------------------------------------
    wire          slow    = mode.short_period_select;
    srt_strobes_t next_strobes;
    assign next_strobes.store   = acquisition_active &&
                                  (slow ? div10_sync_ff : timing_signal);
    assign next_strobes.convert = acquisition_active &&
                                  (!slow ? !timing_signal :
                                   mode.envelope_select ? c5 :
                                   !div10_sync_ff);
    assign next_strobes.meter_clock = slow && timing_signal;

    // Registered so the pins never glitch between selections
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            strobes <= '0;
        else
            strobes <= next_strobes;
    end

    // Rising edge of the store strobe, from the enables that make it
    wire store_rise = acquisition_active && (slow ? div10_rise : ts_rise);

    // -----------------------------------------------------------------
    // Record counter
    // -----------------------------------------------------------------
    wire [11:0] record_preset = mode.pretrigger ? PRESET_PRE : PRESET_POST;
    wire        count_step    = stop && !done && store_rise;
    wire        low_full      = (record_count[7:0] == LOW_FULL);
    wire [11:0] stepped       = {low_full ? 4'(record_count[11:8] + 4'h1)
                                          : record_count[11:8],
                                 8'(record_count[7:0] + 8'h01)};
    wire        reaching_done = count_step && stepped[DONE_BIT];

    // Stop rises on the first store edge after trigger, falls with it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            stop <= 1'b0;
        else if (!triggered)
            stop <= 1'b0;
        else if (store_rise)
            stop <= 1'b1;
    end

    // Preset held while stop is low and reloaded the moment the record ends
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            record_count <= PRESET_POST;
        else if (!stop || reaching_done)
            record_count <= record_preset;
        else if (count_step)
            record_count <= stepped;
    end

    // Done holds for the memory until stop drops for the next record
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            done <= 1'b0;
        else if (!stop)
            done <= 1'b0;
        else if (reaching_done)
            done <= 1'b1;
    end

endmodule : srt_timing

// >>> sim/srt_timing_chk.sv
// Port-level assertion checker for the sample-rate timing block
`timescale 1ns/100ps
module srt_timing_chk
(
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic [3:0]            address,
    input wire logic                  read,
    input wire logic                  write,
    input wire logic [31:0]           writedata,
    input wire logic [31:0]           readdata,
    input wire logic                  waitrequest,
    input wire logic                  acquisition_active,
    input wire logic                  triggered,
    input wire srt_pkg::srt_strobes_t strobes,
    input wire logic                  done
);
    import srt_pkg::*;
    // ----------------------------------------------------------------
    // Shadow settings and store run length
    // ----------------------------------------------------------------
    logic [7:0] rate_q;
    srt_mode_t  mode_q;
    logic       store_d;
    logic [7:0] run;
    logic [7:0] settle;
    wire        req     = read || write;
    wire        acc_wr  = write && !waitrequest;
    wire        slow    = mode_q.short_period_select;
    wire [1:0]  sel     = rate_q[7:6];
    wire        edge_st = strobes.store != store_d;
    wire        calm    = settle > 8'h3C;
    // Settle restarts on any write so that a rate change is never judged mid-switch
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rate_q  <= RATE_RESET;
            mode_q  <= MODE_RESET;
            store_d <= 1'b0;
            run     <= 8'h00;
            settle  <= 8'h00;
        end
        else
        begin
            if (acc_wr && address == REG_RATE)
                rate_q <= writedata[7:0];
            if (acc_wr && address == REG_MODE)
                mode_q <= srt_mode_t'(writedata[3:0]);
            store_d <= strobes.store;
            run     <= edge_st ? 8'h00 : run + {7'h00, run != 8'hFF};
            settle  <= (acc_wr || !acquisition_active) ? 8'h00 : settle + {7'h00, settle != 8'hFF};
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    chk_bus_onewait: assert property (req && !$past(req)
        |-> waitrequest ##1 !waitrequest) else $error("bus wait not one cycle");
    chk_idle_quiet: assert property ((!acquisition_active)[*3]
        |-> !strobes.convert && !strobes.store) else $error("strobe while idle");
    chk_comp_pair: assert property (settle > 8'h03 && !mode_q.envelope_select
        |-> strobes.convert != strobes.store) else $error("strobes not complementary");
    chk_meter_off: assert property ((!slow)[*2]
        |-> !strobes.meter_clock) else $error("meter clock on undivided path");
    chk_fast_toggle: assert property (calm && !slow && sel == SEL_25M
        |-> run <= 8'h02) else $error("25 MHz store held too long");
    chk_fast5_half: assert property (calm && !slow && sel == SEL_5M && edge_st
        |-> run inside {8'h0B, 8'h0C}) else $error("5 MHz half period wrong");
    chk_div10_half: assert property (calm && slow && sel == SEL_25M && edge_st
        |-> run == 8'h18) else $error("divided square wave not symmetric");
    chk_done_trig: assert property ($rose(done) |-> triggered)
        else $error("done without trigger");
    chk_done_clear: assert property ((!triggered)[*2] |=> !done)
        else $error("done held after trigger release");
    cover property ($rose(done));
    cover property (calm && mode_q.envelope_select);
    cover property (calm && slow && edge_st);
endmodule : srt_timing_chk

// >>> sim/srt_acq_model.sv
// Acquisition control partner: drives acquisition_active and trigger, counts store rises
`timescale 1ns/100ps
module srt_acq_model
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  arm,
    input  wire logic                  fire,
    input  wire srt_pkg::srt_strobes_t strobes,
    input  wire logic                  done,
    output logic                       acquisition_active,
    output logic                       triggered,
    output logic                       report,
    output logic [11:0]                rises
);
    import srt_pkg::*;
    logic store_d;
    logic done_d;
    logic done_d2;
    // Trigger holds until released; rises are counted only while triggered
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            store_d            <= 1'b0;
            done_d             <= 1'b0;
            done_d2            <= 1'b0;
            acquisition_active <= 1'b0;
            triggered          <= 1'b0;
            report             <= 1'b0;
            rises              <= 12'h000;
        end
        else
        begin
            store_d            <= strobes.store;
            done_d             <= done;
            acquisition_active <= arm;
            triggered          <= fire;
            done_d2            <= done_d;
            // Late by one so the rise that ends the record is already counted
            report             <= done_d && !done_d2;
            if (!fire)
                rises <= 12'h000;
            else if (triggered && strobes.store && !store_d)
                rises <= rises + 12'h001;
        end
    end
endmodule : srt_acq_model

// >>> sim/tb_srt_timing.sv
// Self-checking bench for the sample-rate timing block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_srt_timing;
    import srt_pkg::*;
    logic clk, reset_n, read, write, waitrequest, acquisition_active, triggered, done;
    logic arm, fire, report, rd_seen, meas_evt;
    logic [3:0]   address;
    logic [31:0]  writedata, readdata, meas_val, want, d, rd_val;
    logic [11:0]  rises;
    srt_strobes_t strobes;
    logic [31:0]  exp_q[$];
    int           failures, checks_done, seed, k;
    logic [7:0]  t_rate [11] = '{8'h00, 8'h40, 8'h80, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00,
                                 8'hFE, 8'hFD};
    logic [3:0]  t_mode [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h3, 4'h3, 4'h1, 4'h0, 4'h0};
    logic [1:0]  t_pick [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [31:0] t_span [11] = '{32'h14, 32'h32, 32'h64, 32'h14, 32'hC8, 32'h1F4, 32'h64,
                                 32'hC8, 32'h14, 32'hC8, 32'h1F4};
    srt_timing srt_timing_i (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .acquisition_active(acquisition_active), .triggered(triggered), .strobes(strobes),
        .done(done));
    srt_acq_model srt_acq_model_i (.clk(clk), .reset_n(reset_n), .arm(arm), .fire(fire),
        .strobes(strobes), .done(done), .acquisition_active(acquisition_active),
        .triggered(triggered), .report(report), .rises(rises));
    always #4 clk = ~clk;
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic give_up(input logic bad);
        if (bad)
        begin
            failures++;
            close_out();
        end
    endtask : give_up
    // One Avalon transfer; held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dd,
                       input logic [31:0] e);
        int n;
        n = 0;
        @(posedge clk);
        read      <= !wr;
        write     <= wr;
        address   <= a;
        writedata <= dd;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        give_up(waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
        if (!wr)
        begin
            rd_val = readdata;
            exp_q.push_back(e);
            rd_seen <= 1'b1;
            @(posedge clk);
            rd_seen <= 1'b0;
        end
    endtask : bus
    // Span of four periods, skipping the first rises while the new setting settles
    task automatic measure(input logic [1:0] w, input logic [31:0] span);
        int t, t0, r;
        logic p, s;
        t = 0;
        t0 = 0;
        r = 0;
        p = 1'b1;
        while (r < 7 && t < 20000)
        begin
            @(posedge clk);
            t++;
            s = w[1] ? strobes.meter_clock : (w[0] ? strobes.convert : strobes.store);
            if (s === 1'b1 && p === 1'b0)
                r++;
            if (r == 3 && t0 == 0)
                t0 = t;
            p = s;
        end
        give_up(r < 7);
        exp_q.push_back(span);
        meas_val <= 32'(t - t0);
        meas_evt <= 1'b1;
        @(posedge clk);
        meas_evt <= 1'b0;
    endtask : measure
    // Trigger right after a store rise so both sides agree on the first counted rise
    task automatic record(input logic [3:0] m, input logic [31:0] pre, input logic [31:0] n);
        int t;
        logic p;
        t = 0;
        bus(1'b1, REG_MODE, {28'h0, m}, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0, pre);
        do
        begin
            p = strobes.store;
            @(posedge clk);
            t++;
        end
        while (!(strobes.store === 1'b1 && p === 1'b0) && t < 100);
        fire <= 1'b1;
        exp_q.push_back(n);
        t = 0;
        while (report !== 1'b1 && t < 5000)
        begin
            @(posedge clk);
            t++;
        end
        give_up(t >= 5000);
        fire <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b0, REG_STATUS, 32'h0, pre);
    endtask : record
    // ----------------------------------------------------------------
    // Watcher and main sequence
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rd_seen || meas_evt || report)
            want = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF;
        if (rd_seen)
            `CHK("readdata", want, rd_val)
        if (meas_evt)
            `CHK("strobe span", want, meas_val)
        if (report)
            `CHK("record rises", want, {20'h0, rises})
    end
    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        {read, write, arm, fire, rd_seen, meas_evt} = 6'h00;
        address = 4'h0;
        writedata = 32'h0;
        meas_val = 32'h0;
        seed = 32'hEF8C4B51;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, REG_RATE, 32'h0, 32'h0);
        bus(1'b0, REG_MODE, 32'h0, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0, 32'h4000);
        for (k = 0; k < 3; k++)
        begin
            d = $random(seed);
            // Chain stays parked at full count so the chain spans need no long wrap
            d[RATE_LO_BIT] = 1'b0;
            bus(1'b1, REG_RATE, d, 32'h0);
            bus(1'b0, REG_RATE, 32'h0, {24'h0, d[7:0]});
            bus(1'b1, REG_MODE, d, 32'h0);
            bus(1'b0, REG_MODE, 32'h0, {28'h0, d[3:0]});
            bus(1'b1, 4'hC, d, 32'h0);
            bus(1'b0, 4'hC, 32'h0, 32'h0);
        end
        bus(1'b1, REG_MODE, 32'h0, 32'h0);
        bus(1'b1, REG_STATUS, d, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0, 32'h4000);
        arm <= 1'b1;
        for (k = 0; k < 11; k++)
        begin
            bus(1'b1, REG_RATE, {24'h0, t_rate[k]}, 32'h0);
            bus(1'b1, REG_MODE, {28'h0, t_mode[k]}, 32'h0);
            measure(t_pick[k], t_span[k]);
        end
        bus(1'b1, REG_RATE, 32'h0, 32'h0);
        record(4'h0, 32'h4000, 32'h1C1);
        record(4'h4, 32'h1C000, 32'h41);
        arm <= 1'b0;
        repeat (8) @(posedge clk);
        close_out();
    end
endmodule : tb_srt_timing
bind srt_timing srt_timing_chk srt_timing_chk_i (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .acquisition_active(acquisition_active),
    .triggered(triggered), .strobes(strobes), .done(done));
